/* File: bench/eac_link_model.sv */
// Far-end link model: lock and error pulses that follow the equalizer setting.
// Assumes the bench clock; the bench picks which settings are good enough.
module eac_link_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [3:0] eq_in,
	input  wire logic [4:0] lock_eq_in,
	input  wire logic [4:0] err_eq_in,
	input  wire logic [2:0] kinds_in,
	output logic            lock_out,
	output logic      [2:0] err_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Too weak a setting drops lock or errs every cycle; 5'h10 means never good
	always_ff @(posedge clk_in) begin
		lock_out <= !rst_in && ({1'b0, eq_in} >= lock_eq_in);
		err_out  <= (rst_in || {1'b0, eq_in} >= err_eq_in) ? 3'h0 : kinds_in;
	end
endmodule : eac_link_model

/* File: bench/eac_top_tb.sv */
// Self-checking bench for the equalizer adaptation control block.
// Assumes the link model shares the 100 MHz bench clock.
module eac_top_tb
	import eac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------
	// Harness
	// ------------------------------------------------
	logic        clk, rst, wr, rd, rsel, lock, locked, mon_on;
	logic [1:0]  wen, crc;
	logic [7:0]  addr, wdata, rdata;
	logic [15:0] relock;
	logic [2:0]  err, kinds;
	logic [3:0]  eq, win;
	logic [4:0]  lock_eq, err_eq;
	int          fails, n_checks;

	eac_top eac_top_i (
		.REF_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .PORT_READ_SEL_IN(rsel), .PORT_WRITE_EN_IN(wen),
		.RELOCK_PERIOD_IN(relock), .LOCK_IN(lock), .CLK_ERR_IN(err[2]),
		.ENC_ERR_IN(err[1]), .PAR_ERR_IN(err[0]), .REG_RDATA_OUT(rdata),
		.EQ_SETTING_OUT(eq), .SAMPLE_WINDOW_OUT(win), .ADAPT_LOCKED_OUT(locked),
		.CRC_FLAG_EN_OUT(crc));

	eac_link_model eac_link_model_i (.clk_in(clk), .rst_in(rst), .eq_in(eq),
		.lock_eq_in(lock_eq), .err_eq_in(err_eq), .kinds_in(kinds),
		.lock_out(lock), .err_out(err));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// One register access; read data is settled by the following falling edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
	endtask : bus

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(rdata, exp);
	endtask : rd_chk

	// Bounded wait for the setting pair to move; cyc is the time taken
	task automatic wait_move(input int lim, output int cyc);
		logic [7:0] p;
		p = {eq, win};
		cyc = 0;
		while ({eq, win} === p) begin
			@(negedge clk);
			cyc++;
			if (cyc > lim) begin
				fails++;
				results();
			end
		end
	endtask : wait_move

	task automatic wait_lock(input int lim);
		int cyc;
		cyc = 0;
		while (locked !== 1'b1) begin
			@(negedge clk);
			cyc++;
			if (cyc > lim) begin
				fails++;
				results();
			end
		end
	endtask : wait_lock

	// Window must stay inside the 9..10 limits once they are programmed
	always @(negedge clk) begin
		if (mon_on) begin
			check({7'h00, win >= 4'h9 && win <= 4'hA}, 8'h01);
		end
	end

	// Fresh start; writes stay within the software limits
	task automatic setup(input logic [15:0] rl, input logic [7:0] ctl, input logic [7:0] th,
		input logic [4:0] le, input logic [4:0] ee, input logic [2:0] k);
		mon_on = 1'b0;
		@(posedge clk);
		rst <= 1'b1;
		relock <= rl;
		lock_eq <= le;
		err_eq <= ee;
		kinds <= k;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bus(1'b1, ADDR_WINDOW_LIMITS, 8'hA9);
		bus(1'b1, ADDR_ERR_THRESH, th);
		bus(1'b1, ADDR_ADAPT_CTL, ctl);
		mon_on = 1'b1;
	endtask : setup

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_reset_vals();
		@(negedge clk);
		check({4'h0, win}, 8'h07);
		check({6'h00, crc}, 8'h00);
		rd_chk(ADDR_RSVD_3D, 8'h6F);
		rd_chk(ADDR_RSVD_3E, 8'h00);
		rd_chk(ADDR_RSVD_3F, 8'h40);
		rd_chk(ADDR_RSVD_40, 8'h00);
		rd_chk(ADDR_WINDOW_LIMITS, 8'hA7);
		rd_chk(ADDR_ADAPT_CTL, 8'h71);
		rd_chk(ADDR_ERR_THRESH, 8'h01);
		rd_chk(ADDR_LINK_CAPS, 8'h00);
		for (int a = 8'h44; a <= 8'h49; a++) begin
			rd_chk(8'(a), 8'h00);
		end
	endtask : t_reset_vals

	task automatic t_regs();
		bus(1'b1, ADDR_ADAPT_CTL, 8'hFF);
		rd_chk(ADDR_ADAPT_CTL, 8'h7F);
		bus(1'b1, ADDR_ERR_THRESH, 8'hFE);
		rd_chk(ADDR_ERR_THRESH, 8'hFE);
		bus(1'b1, 8'h46, 8'h5A);
		rd_chk(8'h46, 8'h00);
		bus(1'b1, ADDR_WINDOW_LIMITS, 8'hE0);
		rd_chk(ADDR_WINDOW_LIMITS, 8'hE0);
		bus(1'b1, ADDR_RSVD_3D, 8'h96);
		rd_chk(ADDR_RSVD_3D, 8'h96);
		rd_chk(8'h50, 8'h00);
	endtask : t_regs

	// Per-port copies: write enables pick targets, read select picks one
	// Encoder CRC disable lives outside this block; taken as cleared
	task automatic t_caps();
		logic [1:0] we [3] = '{2'b01, 2'b10, 2'b11};
		logic [7:0] d [3] = '{8'h10, 8'h13, 8'h00};
		logic [7:0] r1 [3] = '{8'h00, 8'h13, 8'h00};
		logic [1:0] xc [3] = '{2'b01, 2'b11, 2'b00};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			wen <= we[i];
			rsel <= 1'b0;
			bus(1'b1, ADDR_LINK_CAPS, d[i]);
			rd_chk(ADDR_LINK_CAPS, (i == 1) ? 8'h10 : d[i]);
			@(posedge clk);
			rsel <= 1'b1;
			rd_chk(ADDR_LINK_CAPS, r1[i]);
			check({6'h00, crc}, {6'h00, xc[i]});
		end
	endtask : t_caps

	// One step: errors do not stop locking; only the threshold re-adapts
	task automatic t_one_step();
		int c;
		setup(16'h0010, 8'h71, 8'hFF, 5'h00, 5'h03, 3'h7);
		wait_lock(60);
		check({4'h0, eq}, 8'h00);
		repeat (60) @(negedge clk);
		check({3'h0, locked, eq}, 8'h10);
		bus(1'b1, ADDR_ERR_THRESH, 8'h01);
		wait_move(20, c);
		check({4'h0, eq}, 8'h01);
	endtask : t_one_step

	// Two step: each error kind alone, checking off, and a masked kind
	task automatic t_two_step();
		logic [2:0] sel [5] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h2};
		logic [2:0] knd [5] = '{3'h4, 3'h2, 3'h1, 3'h7, 3'h1};
		logic [3:0] xeq [5] = '{4'h3, 4'h3, 4'h3, 4'h0, 4'h0};
		int c;
		for (int i = 0; i < 5; i++) begin
			setup(16'h0010, {1'b0, sel[i], 4'h5}, 8'hFF, 5'h00, 5'h03, knd[i]);
			if (i == 0) begin
				wait_move(40, c);
				wait_move(40, c);
				check({7'h00, c > 8 && c < 16}, 8'h01);
			end
			wait_lock(200);
			check({4'h0, eq}, {4'h0, xeq[i]});
		end
	endtask : t_two_step

	// Never locks, so every window advances the search; compare each step
	task automatic t_order();
		logic [7:0] cfg [3] = '{8'h71, 8'h73, 8'h72};
		logic [3:0] pe, pw, ee, ew;
		int c;
		for (int i = 0; i < 3; i++) begin
			setup(16'h0004, cfg[i], 8'hFF, 5'h10, 5'h00, 3'h0);
			wait_move(40, c);
			for (int j = 0; j < 16; j++) begin
				pe = eq;
				pw = win;
				wait_move(40, c);
				ee = pe;
				ew = pw;
				if (!cfg[i][0]) begin
					ee = pe + 4'h1;
				end else if (!cfg[i][1]) begin
					ee = pe + 4'h1;
					ew = (pe == 4'hF) ? ((pw == 4'hA) ? 4'h9 : 4'hA) : pw;
				end else begin
					ew = (pw == 4'hA) ? 4'h9 : 4'hA;
					ee = (pw == 4'hA) ? pe + 4'h1 : pe;
				end
				check({eq, win}, {ee, ew});
				check(8'(c), 8'h04);
			end
		end
	endtask : t_order

	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		rsel = 1'b0;
		wen = 2'b00;
		relock = 16'h0010;
		lock_eq = 5'h10;
		err_eq = 5'h00;
		kinds = 3'h0;
		mon_on = 1'b0;
		fails = 0;
		n_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset_vals();
		t_regs();
		t_caps();
		t_one_step();
		t_two_step();
		t_order();
		results();
	end
endmodule : eac_top_tb

/* File: core/eac_err_accum.sv */
// Error accumulator for the equalizer adaptation control block.
// Assumes error pulses come from logic on the same clock.
module eac_err_accum
	import eac_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             clear_in,
	input  wire logic [2:0]       err_in,
	input  wire logic [2:0]       sel_in,
	output logic      [CNT_W-1:0] count_out,
	output logic                  any_out
);

	// ----------------------------------------------------------------
	// Selection and accumulation
	// ----------------------------------------------------------------
	logic [2:0]       hit;
	logic [1:0]       hit_sum;
	logic [CNT_W:0]   count_wide;
	logic [CNT_W-1:0] count_reg;

	// Only selected error kinds count toward the total
	assign hit        = err_in & sel_in;
	assign hit_sum    = {1'b0, hit[ERR_CLK_BIT]} + {1'b0, hit[ERR_ENC_BIT]}
		+ {1'b0, hit[ERR_PAR_BIT]};
	assign any_out    = |hit;
	assign count_wide = {1'b0, count_reg} + {{(CNT_W-1){1'b0}}, hit_sum};

	// Saturates so a noisy link never wraps back under the threshold
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count_reg <= '0;
		end else if (clear_in) begin
			count_reg <= '0;
		end else if (count_wide[CNT_W]) begin
			count_reg <= '1;
		end else begin
			count_reg <= count_wide[CNT_W-1:0];
		end
	end

	assign count_out = count_reg;

endmodule : eac_err_accum

/* File: core/eac_pkg.sv */
// Constants shared by the equalizer adaptation control block.
// Assumes an 8-bit register address space reached by a byte-wide access port.
package eac_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RSVD_3D       = 8'h3D;
	localparam logic [7:0] ADDR_RSVD_3E       = 8'h3E;
	localparam logic [7:0] ADDR_RSVD_3F       = 8'h3F;
	localparam logic [7:0] ADDR_RSVD_40       = 8'h40;
	localparam logic [7:0] ADDR_WINDOW_LIMITS = 8'h41;
	localparam logic [7:0] ADDR_ADAPT_CTL     = 8'h42;
	localparam logic [7:0] ADDR_ERR_THRESH    = 8'h43;
	localparam logic [7:0] ADDR_RO_FIRST      = 8'h44;
	localparam logic [7:0] ADDR_RO_LAST       = 8'h49;
	localparam logic [7:0] ADDR_LINK_CAPS     = 8'h4A;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int UPPER_LSB      = 4;
	localparam int LOWER_LSB      = 0;
	localparam int ERR_SEL_LSB    = 4;
	localparam int CTL_SPARE_BIT  = 3;
	localparam int TWO_STEP_BIT   = 2;
	localparam int LOOP_ORDER_BIT = 1;
	localparam int WIN_EN_BIT     = 0;
	localparam int CRC_FLAG_BIT   = 4;
	localparam int ERR_CLK_BIT    = 2;
	localparam int ERR_ENC_BIT    = 1;
	localparam int ERR_PAR_BIT    = 0;

	// ----------------------------------------------------------------
	// Values after reset and setting limits
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_RSVD_3D    = 8'h6F;
	localparam logic [7:0] RST_RSVD_3E    = 8'h00;
	localparam logic [7:0] RST_RSVD_3F    = 8'h40;
	localparam logic [7:0] RST_RSVD_40    = 8'h00;
	localparam logic [3:0] RST_UPPER      = 4'hA;
	localparam logic [3:0] RST_LOWER      = 4'h7;
	localparam logic [2:0] RST_ERR_SEL    = 3'h7;
	localparam logic       RST_CTL_SPARE  = 1'b0;
	localparam logic       RST_TWO_STEP   = 1'b0;
	localparam logic       RST_LOOP_ORDER = 1'b0;
	localparam logic       RST_WIN_EN     = 1'b1;
	localparam logic [7:0] RST_THRESH     = 8'h01;
	localparam logic [7:0] RST_LINK_CAPS  = 8'h00;
	localparam logic [7:0] RO_VALUE       = 8'h00;
	localparam logic [3:0] WINDOW_TOP     = 4'hE;
	localparam logic [3:0] EQ_TOP         = 4'hF;
	localparam logic [3:0] RST_EQ         = 4'h0;

	// ----------------------------------------------------------------
	// Adaptation states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_SETTLE = 3'b001,
		ST_VERIFY = 3'b010,
		ST_TRACK  = 3'b100
	} eac_state_t;

endpackage : eac_pkg

/* File: core/eac_top.sv */
// Receive equalizer adaptation control with its configuration registers.
// Assumes lock, error pulses and port selection come from logic on REF_CLK_IN.
module eac_top
	import eac_pkg::*;
#(
	parameter int NUM_PORTS = 2,
	parameter int RELOCK_W  = 16,
	parameter int CNT_W     = 8
) (
	input  wire logic                 REF_CLK_IN,
	input  wire logic                 RESET_IN,
	input  wire logic [7:0]           REG_ADDR_IN,
	input  wire logic [7:0]           REG_WDATA_IN,
	input  wire logic                 REG_WR_IN,
	input  wire logic                 REG_RD_IN,
	input  wire logic                 PORT_READ_SEL_IN,
	input  wire logic [NUM_PORTS-1:0] PORT_WRITE_EN_IN,
	input  wire logic [RELOCK_W-1:0]  RELOCK_PERIOD_IN,
	input  wire logic                 LOCK_IN,
	input  wire logic                 CLK_ERR_IN,
	input  wire logic                 ENC_ERR_IN,
	input  wire logic                 PAR_ERR_IN,
	output logic      [7:0]           REG_RDATA_OUT,
	output logic      [3:0]           EQ_SETTING_OUT,
	output logic      [3:0]           SAMPLE_WINDOW_OUT,
	output logic                      ADAPT_LOCKED_OUT,
	output logic      [NUM_PORTS-1:0] CRC_FLAG_EN_OUT
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [7:0] rsvd_3d_reg, rsvd_3e_reg, rsvd_3f_reg, rsvd_40_reg;
	logic [3:0] upper_reg, lower_reg;
	logic [2:0] err_sel_reg;
	logic       ctl_spare_reg, two_step_reg, loop_order_reg, win_en_reg;
	logic [7:0] thresh_reg;
	logic [7:0] link_caps_reg [NUM_PORTS];
	logic [7:0] rdata_reg, rd_mux;

	// Shared registers; read-only and unmapped writes are dropped
	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			rsvd_3d_reg    <= RST_RSVD_3D;
			rsvd_3e_reg    <= RST_RSVD_3E;
			rsvd_3f_reg    <= RST_RSVD_3F;
			rsvd_40_reg    <= RST_RSVD_40;
			upper_reg      <= RST_UPPER;
			lower_reg      <= RST_LOWER;
			err_sel_reg    <= RST_ERR_SEL;
			ctl_spare_reg  <= RST_CTL_SPARE;
			two_step_reg   <= RST_TWO_STEP;
			loop_order_reg <= RST_LOOP_ORDER;
			win_en_reg     <= RST_WIN_EN;
			thresh_reg     <= RST_THRESH;
		end else if (REG_WR_IN) begin
			unique case (REG_ADDR_IN)
				ADDR_RSVD_3D: rsvd_3d_reg <= REG_WDATA_IN;
				ADDR_RSVD_3E: rsvd_3e_reg <= REG_WDATA_IN;
				ADDR_RSVD_3F: rsvd_3f_reg <= REG_WDATA_IN;
				ADDR_RSVD_40: rsvd_40_reg <= REG_WDATA_IN;
				ADDR_WINDOW_LIMITS: begin
					upper_reg <= REG_WDATA_IN[UPPER_LSB +: 4];
					lower_reg <= REG_WDATA_IN[LOWER_LSB +: 4];
				end
				ADDR_ADAPT_CTL: begin
					err_sel_reg    <= REG_WDATA_IN[ERR_SEL_LSB +: 3];
					ctl_spare_reg  <= REG_WDATA_IN[CTL_SPARE_BIT];
					two_step_reg   <= REG_WDATA_IN[TWO_STEP_BIT];
					loop_order_reg <= REG_WDATA_IN[LOOP_ORDER_BIT];
					win_en_reg     <= REG_WDATA_IN[WIN_EN_BIT];
				end
				ADDR_ERR_THRESH: thresh_reg <= REG_WDATA_IN;
				default: ;
			endcase
		end
	end

	// Per-port copies; a write may reach several ports at once
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		always_ff @(posedge REF_CLK_IN) begin
			if (RESET_IN) begin
				link_caps_reg[p] <= RST_LINK_CAPS;
			end else if (REG_WR_IN && REG_ADDR_IN == ADDR_LINK_CAPS && PORT_WRITE_EN_IN[p]) begin
				link_caps_reg[p] <= REG_WDATA_IN;
			end
		end
		assign CRC_FLAG_EN_OUT[p] = link_caps_reg[p][CRC_FLAG_BIT];
	end

	// Read selection; spare control bit 7 reads as zero
	always_comb begin
		rd_mux = 8'h00;
		if (REG_ADDR_IN >= ADDR_RO_FIRST && REG_ADDR_IN <= ADDR_RO_LAST) begin
			rd_mux = RO_VALUE;
		end else begin
			unique case (REG_ADDR_IN)
				ADDR_RSVD_3D:       rd_mux = rsvd_3d_reg;
				ADDR_RSVD_3E:       rd_mux = rsvd_3e_reg;
				ADDR_RSVD_3F:       rd_mux = rsvd_3f_reg;
				ADDR_RSVD_40:       rd_mux = rsvd_40_reg;
				ADDR_WINDOW_LIMITS: rd_mux = {upper_reg, lower_reg};
				ADDR_ADAPT_CTL:     rd_mux = {1'b0, err_sel_reg, ctl_spare_reg,
					two_step_reg, loop_order_reg, win_en_reg};
				ADDR_ERR_THRESH:    rd_mux = thresh_reg;
				ADDR_LINK_CAPS:     rd_mux = link_caps_reg[PORT_READ_SEL_IN];
				default:            rd_mux = 8'h00;
			endcase
		end
	end

	// Read data held until the next read
	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			rdata_reg <= 8'h00;
		end else if (REG_RD_IN) begin
			rdata_reg <= rd_mux;
		end
	end
	assign REG_RDATA_OUT = rdata_reg;

	// ----------------------------------------------------------------
	// Window timing and error counting
	// ----------------------------------------------------------------
	eac_state_t        state_reg;
	logic [RELOCK_W-1:0] timer_reg, target, full_period, half_period;
	logic              window_end, restart, check_en, err_any, over_thresh;
	logic [CNT_W-1:0]  err_count;

	// A zero period still lasts one cycle so the machine never stalls
	assign full_period = (RELOCK_PERIOD_IN == '0) ? RELOCK_W'(1) : RELOCK_PERIOD_IN;
	assign half_period = (RELOCK_PERIOD_IN < RELOCK_W'(2)) ? RELOCK_W'(1)
		: (RELOCK_PERIOD_IN >> 1);
	assign target      = (state_reg == ST_SETTLE && !two_step_reg) ? full_period
		: half_period;
	assign window_end  = (timer_reg == target - RELOCK_W'(1));
	assign check_en    = |err_sel_reg;
	assign over_thresh = check_en && (err_count > thresh_reg);

	// Timer restarts whenever a window or setting starts over
	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN || restart) begin
			timer_reg <= '0;
		end else begin
			timer_reg <= timer_reg + RELOCK_W'(1);
		end
	end

	eac_err_accum #(
		.CNT_W(CNT_W)
	) eac_err_accum_i (
		.clk_in   (REF_CLK_IN),
		.rst_in   (RESET_IN),
		.clear_in (restart),
		.err_in   ({CLK_ERR_IN, ENC_ERR_IN, PAR_ERR_IN}),
		.sel_in   (err_sel_reg),
		.count_out(err_count),
		.any_out  (err_any)
	);

	// ----------------------------------------------------------------
	// Setting search
	// ----------------------------------------------------------------
	logic [3:0] eq_reg, sw_reg, eq_next, sw_next, win_hi, sw_step;
	logic       eq_wrap, sw_wrap, advance, raise;

	// Window upper bound never exceeds the legal top code
	assign win_hi  = (upper_reg > WINDOW_TOP) ? WINDOW_TOP : upper_reg;
	assign eq_wrap = (eq_reg == EQ_TOP);
	assign sw_wrap = (sw_reg >= win_hi);

	function automatic logic [3:0] clamp_win(input logic [3:0] v, input logic [3:0] lo,
		input logic [3:0] hi);
		clamp_win = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp_win

	// Next setting of the nested search
	always_comb begin
		sw_step = sw_wrap ? lower_reg : sw_reg + 4'h1;
		eq_next = eq_wrap ? RST_EQ : eq_reg + 4'h1;
		sw_next = sw_reg;
		if (win_en_reg) begin
			if (!loop_order_reg) begin
				sw_next = eq_wrap ? sw_step : sw_reg;
			end else begin
				sw_next = sw_step;
				eq_next = sw_wrap ? eq_next : eq_reg;
			end
		end
	end

	// Settings; limits are reapplied every cycle in case software moves them
	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			eq_reg <= RST_EQ;
			sw_reg <= RST_LOWER;
		end else if (advance) begin
			eq_reg <= eq_next;
			sw_reg <= clamp_win(sw_next, lower_reg, win_hi);
		end else begin
			if (raise && !eq_wrap) begin
				eq_reg <= eq_reg + 4'h1;
			end
			sw_reg <= clamp_win(sw_reg, lower_reg, win_hi);
		end
	end

	// ----------------------------------------------------------------
	// Adaptation state machine
	// ----------------------------------------------------------------
	eac_state_t state_next;
	always_comb begin
		state_next = state_reg;
		advance    = 1'b0;
		raise      = 1'b0;
		restart    = 1'b0;
		unique case (state_reg)
			ST_SETTLE: begin
				if (window_end) begin
					restart = 1'b1;
					if (two_step_reg) begin
						state_next = ST_VERIFY;
					end else if (LOCK_IN) begin
						state_next = ST_TRACK;
					end else begin
						advance = 1'b1;
					end
				end
			end
			ST_VERIFY: begin
				// Errors end the check early rather than wasting the window
				if (err_any || (window_end && !LOCK_IN)) begin
					advance    = 1'b1;
					restart    = 1'b1;
					state_next = ST_SETTLE;
				end else if (window_end) begin
					restart    = 1'b1;
					state_next = ST_TRACK;
				end
			end
			ST_TRACK: begin
				if (!LOCK_IN) begin
					advance    = 1'b1;
					restart    = 1'b1;
					state_next = ST_SETTLE;
				end else if (window_end) begin
					restart = 1'b1;
					if (over_thresh) begin
						raise      = 1'b1;
						state_next = ST_SETTLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			state_reg <= ST_SETTLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign EQ_SETTING_OUT    = eq_reg;
	assign SAMPLE_WINDOW_OUT = sw_reg;
	assign ADAPT_LOCKED_OUT  = (state_reg == ST_TRACK);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (RESET_IN);

	a_limit_reset: assert property ($fell(RESET_IN) |->
		upper_reg == 4'hA && lower_reg == 4'h7)
		else $error("window limits wrong after reset");
	a_window_range: assert property (
		$past(lower_reg) <= $past(win_hi) && $stable(lower_reg) && $stable(upper_reg)
		|-> sw_reg >= lower_reg && sw_reg <= win_hi)
		else $error("window setting outside limits");
	a_check_off: assert property ((err_sel_reg == 3'h0 && err_count == '0)
		|=> err_count == '0)
		else $error("errors counted with checking disabled");
	a_window_clear: assert property (restart |=> err_count == '0)
		else $error("error count not restarted");
	a_raise_step: assert property ((state_reg == ST_TRACK && LOCK_IN && window_end
		&& over_thresh && eq_reg != EQ_TOP) |=> state_reg == ST_SETTLE
		&& eq_reg == $past(eq_reg) + 4'h1)
		else $error("equalizer not raised over threshold");
	a_one_step: assert property ((state_reg == ST_SETTLE && !two_step_reg)
		|-> timer_reg < full_period)
		else $error("one-step wait overran period");
	a_two_step: assert property ((state_reg == ST_SETTLE && two_step_reg
		&& window_end) |=> state_reg == ST_VERIFY ##0 timer_reg == '0)
		else $error("two-step did not enter verify");
	a_early_move: assert property ((state_reg == ST_VERIFY && err_any)
		|=> state_reg == ST_SETTLE && timer_reg == '0)
		else $error("error in verify did not advance");
	a_win_frozen: assert property ((advance && !win_en_reg
		&& $stable(upper_reg) && $stable(lower_reg)) |=> $stable(sw_reg))
		else $error("window stepped while excluded");
	a_ro_read: assert property ((REG_RD_IN && REG_ADDR_IN >= 8'h44
		&& REG_ADDR_IN <= 8'h49) |=> REG_RDATA_OUT == 8'h00)
		else $error("read-only location not zero");
	a_port_guard: assert property ((REG_WR_IN && REG_ADDR_IN == ADDR_LINK_CAPS
		&& !PORT_WRITE_EN_IN[0]) |=> $stable(CRC_FLAG_EN_OUT[0]))
		else $error("unselected port copy written");

	c_verify_pass: cover property (state_reg == ST_VERIFY ##1 state_reg == ST_TRACK);
	c_readapt:     cover property (state_reg == ST_TRACK && raise);
	c_early_exit:  cover property (state_reg == ST_VERIFY && err_any);
	c_search_wrap: cover property (advance && eq_wrap && win_en_reg);
endmodule : eac_top
